// ---- verilog/epw_consts.vh ----
// Constants for the EEPROM page write host controller
`ifndef EPW_CONSTS_VH
`define EPW_CONSTS_VH
// Register byte offsets
`define EPW_REG_CTRL 12'h000
`define EPW_REG_ADDR 12'h004
`define EPW_REG_DATA 12'h008
`define EPW_REG_STAT 12'h00C
`define EPW_REG_IRQ 12'h010
`define EPW_REG_MASK 12'h014
// Control fields
`define EPW_CTRL_GO 0
`define EPW_CTRL_LAST 1
`define EPW_CTRL_MODE_LO 2
`define EPW_CTRL_MODE_HI 3
// Completion modes
`define EPW_MODE_WAIT 2'h0
`define EPW_MODE_TOGGLE 2'h1
`define EPW_MODE_POLL 2'h2
`define EPW_MODE_RDY 2'h3
// Status fields
`define EPW_STAT_BUSY 0
`define EPW_STAT_LOADING 1
`define EPW_STAT_OVER 2
// Interrupt fields
`define EPW_IRQ_DONE 0
`define EPW_IRQ_OVER 1
// Timing: figures as printed, cycles derived at 10 ns
`define EPW_CLK_NS 10
`define EPW_PROG_MS 10
`define EPW_PROG_CYC ((`EPW_PROG_MS * 1000000 + `EPW_CLK_NS - 1) / `EPW_CLK_NS)
`define EPW_LOAD_GAP_US 30
`define EPW_LOAD_GAP_CYC ((`EPW_LOAD_GAP_US * 1000) / `EPW_CLK_NS)
`define EPW_PULSE_NS 100
`define EPW_PULSE_CYC ((`EPW_PULSE_NS + `EPW_CLK_NS - 1) / `EPW_CLK_NS)
`define EPW_READ_NS 100
`define EPW_READ_CYC ((`EPW_READ_NS + `EPW_CLK_NS - 1) / `EPW_CLK_NS)
`define EPW_POST_NS 0
`define EPW_PAGE_BYTES 64
`endif

// ---- verilog/epw_host.v ----
// Host controller that page-writes an external byte-wide EEPROM
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - Blind host waits 10 ms before next access
// - Polling host resumes at once on completion
// - Toggle completion means two equal toggle reads; poll completion means bit 7 equals that of the last byte
// - Poll reads keep one fixed address
// - One load carries 1 to 64 bytes
// - Next byte starts within 30 us
`include "epw_consts.vh"
module epw_host #(
	parameter PROG_CYC = `EPW_PROG_CYC,
	parameter GAP_CYC = `EPW_LOAD_GAP_CYC
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	output reg irq,
	output reg [14:0] mem_addr,
	input wire [7:0] mem_data_in,
	output reg [7:0] mem_data_out,
	output reg mem_data_oe,
	output reg chip_en_n,
	output reg out_en_n,
	output reg write_en_n,
	input wire ready_busy_n
);
	// ==================================================
	// Register file
	localparam S_IDLE = 3'h0, S_WRLO = 3'h1, S_WRHI = 3'h2, S_GAP = 3'h3;
	localparam S_WAIT = 3'h4, S_RDLO = 3'h5, S_RDHI = 3'h6;
	// Pin timing counts, cut to the timer width where they are loaded
	localparam PULSE_CYC = `EPW_PULSE_CYC;
	localparam READ_CYC = `EPW_READ_CYC;
	reg [2:0] state;
	reg [1:0] mode;
	reg last;
	reg go;
	reg [14:0] addr_reg;
	reg [7:0] data_reg;
	reg [8:0] page;
	reg [6:0] count;
	reg [1:0] irq_stat;
	reg [1:0] irq_mask;
	reg [23:0] timer;
	reg [7:0] prev_read;
	reg have_prev;
	reg [7:0] last_byte;
	reg next_idle;
	reg over_ev;
	wire acc = psel && penable;
	// Done pulses as the sequencer drops back to idle
	wire done_ev = (state == S_WAIT || state == S_RDHI) && next_idle;
	// Completion test for each mode
	always @* begin
		next_idle = 1'b0;
		if (state == S_WAIT) begin
			if (mode == `EPW_MODE_WAIT)
				next_idle = (timer == 24'h000000);
			else if (mode == `EPW_MODE_RDY)
				next_idle = ready_busy_n && timer == 24'h000000;
		end else if (state == S_RDHI && timer == 24'h000000) begin
			if (mode == `EPW_MODE_TOGGLE)
				next_idle = have_prev && (prev_read[6] == mem_data_in[6]);
			else
				next_idle = (mem_data_in[7] == last_byte[7]);
		end
	end
	// APB slave: one wait state, unmapped reads zero and flag error
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			mode <= 2'h0;
			last <= 1'b0;
			go <= 1'b0;
			addr_reg <= 15'h0000;
			data_reg <= 8'h00;
			irq_mask <= 2'h0;
			irq_stat <= 2'h0;
			irq <= 1'b0;
		end else begin
			// Answer only once the access phase is seen, so the write lands
			pready <= acc && !pready;
			pslverr <= 1'b0;
			if (state == S_WRLO)
				go <= 1'b0;
			if (acc && !pready) begin
				pslverr <= (paddr > `EPW_REG_MASK) || (paddr[1:0] != 2'h0);
				prdata <= 32'h00000000;
				if (pwrite) begin
					case (paddr)
					`EPW_REG_CTRL: begin
						mode <= pwdata[`EPW_CTRL_MODE_HI:`EPW_CTRL_MODE_LO];
						last <= pwdata[`EPW_CTRL_LAST];
						go <= pwdata[`EPW_CTRL_GO];
					end
					`EPW_REG_ADDR: addr_reg <= pwdata[14:0];
					`EPW_REG_DATA: data_reg <= pwdata[7:0];
					`EPW_REG_MASK: irq_mask <= pwdata[1:0];
					default: ;
					endcase
				end else begin
					case (paddr)
					`EPW_REG_CTRL: prdata <= {28'h0000000, mode, last, go};
					`EPW_REG_ADDR: prdata <= {17'h00000, addr_reg};
					`EPW_REG_DATA: prdata <= {24'h000000, prev_read};
					`EPW_REG_STAT: prdata <= {22'h000000, count, state == S_GAP,
						state == S_GAP, state != S_IDLE};
					`EPW_REG_IRQ: prdata <= {30'h00000000, irq_stat};
					`EPW_REG_MASK: prdata <= {30'h00000000, irq_mask};
					default: ;
					endcase
				end
			end
			// Set wins over write-one-to-clear
			irq_stat <= (irq_stat & ~((acc && !pready && pwrite && paddr == `EPW_REG_IRQ)
				? pwdata[1:0] : 2'h0)) | {over_ev, done_ev};
			irq <= |(irq_stat & irq_mask);
		end
	end
	// ==================================================
	// Pin sequencer
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= S_IDLE;
			mem_addr <= 15'h0000;
			mem_data_out <= 8'h00;
			mem_data_oe <= 1'b0;
			chip_en_n <= 1'b1;
			out_en_n <= 1'b1;
			write_en_n <= 1'b1;
			timer <= 24'h000000;
			page <= 9'h000;
			count <= 7'h00;
			prev_read <= 8'h00;
			have_prev <= 1'b0;
			last_byte <= 8'h00;
			over_ev <= 1'b0;
		end else begin
			over_ev <= 1'b0;
			if (timer != 24'h000000)
				timer <= timer - 24'h000001;
			case (state)
			S_IDLE, S_GAP: begin
				if (state == S_GAP && timer == 24'h000000) begin
					// Missed the byte window: device closes the load itself
					state <= S_WAIT;
					timer <= PROG_CYC[23:0];
					have_prev <= 1'b0;
				end else if (go) begin
					// Page bits held from the first byte of a load
					mem_addr <= {(state == S_GAP) ? page : addr_reg[14:6],
						addr_reg[5:0]};
					if (state == S_IDLE)
						page <= addr_reg[14:6];
					mem_data_out <= data_reg;
					last_byte <= data_reg;
					mem_data_oe <= 1'b1;
					chip_en_n <= 1'b0;
					write_en_n <= 1'b0;
					out_en_n <= 1'b1;
					timer <= PULSE_CYC[23:0];
					state <= S_WRLO;
				end
			end
			S_WRLO: if (timer == 24'h000000) begin
				write_en_n <= 1'b1;
				count <= count + 7'h01;
				state <= S_WRHI;
			end
			S_WRHI: begin
				chip_en_n <= 1'b1;
				mem_data_oe <= 1'b0;
				if (last || count == `EPW_PAGE_BYTES) begin
					// Full page or software end: let the strobe idle out
					over_ev <= !last;
					state <= S_WAIT;
					timer <= (mode == `EPW_MODE_WAIT) ? PROG_CYC[23:0] : 24'h000000;
					have_prev <= 1'b0;
				end else begin
					timer <= GAP_CYC[23:0] - PULSE_CYC[23:0];
					state <= S_GAP;
				end
			end
			S_WAIT: begin
				if (next_idle) begin
					state <= S_IDLE;
					count <= 7'h00;
				end else if (mode == `EPW_MODE_TOGGLE || mode == `EPW_MODE_POLL) begin
					// Same address every poll so the toggle is meaningful
					mem_addr <= {page, 6'h00};
					chip_en_n <= 1'b0;
					out_en_n <= 1'b0;
					timer <= READ_CYC[23:0];
					state <= S_RDLO;
				end
			end
			S_RDLO: if (timer == 24'h000000) begin
				state <= S_RDHI;
			end
			S_RDHI: begin
				prev_read <= mem_data_in;
				have_prev <= 1'b1;
				chip_en_n <= 1'b1;
				out_en_n <= 1'b1;
				count <= next_idle ? 7'h00 : count;
				state <= next_idle ? S_IDLE : S_WAIT;
			end
			default: state <= S_IDLE;
			endcase
		end
	end
endmodule // epw_host
`default_nettype wire

// ---- testbench/epw_host_props.sv ----
// Pin and bus checks for the page write host
`timescale 1ns/1ns
`default_nettype none
module epw_host_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [14:0] mem_addr,
	input wire logic mem_data_oe,
	input wire logic chip_en_n,
	input wire logic out_en_n,
	input wire logic write_en_n
);
	// ==========
	// One clock domain, so shared clocking
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_we_width: assert property ($fell(write_en_n) |-> !write_en_n [*8])
		else $error("write strobe too short");
	a_we_drive: assert property (!write_en_n |-> mem_data_oe && !chip_en_n && out_en_n)
		else $error("write strobe without data");
	a_poll_addr: assert property (!out_en_n |-> mem_addr[5:0] == 6'h00 && !mem_data_oe)
		else $error("status read moved or driven");
	a_addr_hold: assert property (!chip_en_n && $past(!chip_en_n) |-> $stable(mem_addr))
		else $error("address moved in access");
	a_read_len: assert property ($fell(out_en_n) |-> !out_en_n [*8])
		else $error("status read too short");
	a_apb_wait: assert property (psel && penable && !pready |=> pready)
		else $error("bus answer late");
	a_ready_once: assert property (pready |=> !pready)
		else $error("bus answer held");
	a_err_pulse: assert property (pslverr |-> pready)
		else $error("error without answer");
endmodule // epw_host_props
`default_nettype wire

// ---- testbench/epw_eeprom_model.sv ----
// Behavioural page-write memory on the far side of the host
`timescale 1ns/1ns
`default_nettype none
module epw_eeprom_model #(
	parameter int CLOSE_NS = 300,
	parameter int PROG_NS = 1000
) (
	input wire logic [14:0] mem_addr,
	input wire logic [7:0] mem_data_out,
	input wire logic chip_en_n,
	input wire logic out_en_n,
	input wire logic write_en_n,
	output logic [7:0] data_rd,
	output logic ready_busy_n
);
	// ==========
	// Array and load state
	logic [7:0] mem [0:32767];
	logic [8:0] page;
	logic [7:0] last, q = 8'h00;
	logic busy = 0, loaded = 0, tog;
	int progs = 0, slips = 0;
	time t_up;
	initial foreach (mem[i]) mem[i] = 8'h00;
	// Delay lets address settle past the strobe edge
	always @(negedge write_en_n) #1 if (!busy) begin
		if (!loaded) begin
			page = mem_addr[14:6];
			tog = 1;
		end
		loaded = 1;
	end
	// A later byte on another page would be silently redirected
	always @(posedge write_en_n) if (loaded && !busy) begin
		if (mem_addr[14:6] != page) slips++;
		mem[{page, mem_addr[5:0]}] = mem_data_out;
		last = mem_data_out;
		t_up = $time;
	end
	// Idle strobe closes the load, one program for all bytes
	always #10 if (loaded && write_en_n && $time - t_up >= CLOSE_NS) begin
		busy = 1;
		loaded = 0;
		progs++;
		#PROG_NS busy = 0;
	end
	// Status from the first byte on, as the busy pin; a released bus shows inverted data
	always @(negedge out_en_n) #1 q = (busy || loaded) ? {~last[7], tog, 6'h00} :
		mem[mem_addr];
	always @(posedge out_en_n) if (busy || loaded) tog = ~tog;
	assign data_rd = (!out_en_n && !chip_en_n) ? q : ~q;
	assign ready_busy_n = !(busy || loaded);
endmodule // epw_eeprom_model
`default_nettype wire

// ---- testbench/epw_host_tb_top.sv ----
// Self-checking bench for the page write host
`timescale 1ns/1ns
`default_nettype none
`include "epw_consts.vh"
module epw_host_tb_top;
	// ==========
	// Clock, pins and counters
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, serr;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, rd;
	wire [31:0] prdata;
	wire [14:0] mem_addr;
	wire [7:0] mem_data_in, mem_data_out;
	wire pready, pslverr, irq, mem_data_oe, chip_en_n, out_en_n, write_en_n, ready_busy_n;
	int err_total = 0, check_count = 0, cyc = 0;
	always #5 pclk = ~pclk;
	epw_host #(.PROG_CYC(200), .GAP_CYC(50)) epw_host_inst (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq, .mem_addr, .mem_data_in,
		.mem_data_out, .mem_data_oe, .chip_en_n, .out_en_n, .write_en_n, .ready_busy_n);
	epw_eeprom_model epw_eeprom_model_inst (.mem_addr, .mem_data_out, .chip_en_n, .out_en_n,
		.write_en_n, .data_rd(mem_data_in), .ready_busy_n);
	// ==========
	// Bus access, compare and verdict
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		serr = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic complete_run;
		if (err_total == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Loads n bytes from offset zero; spacing stays under the close window.
	// Later bytes name a wrong page, and a full page goes without the last flag.
	task automatic page(input logic [14:0] a, input int n, input logic [1:0] m);
		int i, p, k;
		p = epw_eeprom_model_inst.progs;
		for (i = 0; i < n; i++) begin
			apb(1, `EPW_REG_ADDR, {17'h0, (a + 15'(i)) ^ (i > 0 ? 15'h4000 : 15'h0000)});
			apb(1, `EPW_REG_DATA, 32'hA5 ^ i);
			apb(1, `EPW_REG_CTRL, {28'h0, m, i == n - 1 && n < 64, 1'b1});
			repeat (14) @(posedge pclk);
		end
		k = 0;
		while (irq !== 1'b1 && k < 5000) begin
			@(posedge pclk);
			k++;
		end
		chk(irq, 1);
		chk(epw_eeprom_model_inst.busy, 0);
		chk(epw_eeprom_model_inst.progs, p + 1);
		chk(epw_eeprom_model_inst.slips, 0);
		for (i = 0; i < n; i++) chk(epw_eeprom_model_inst.mem[a + i], 32'hA5 ^ i);
	endtask
	// Hang guard
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			complete_run;
		end
	end
	// ==========
	// Every completion mode, then mask, clear and bad address
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1;
		apb(1, `EPW_REG_MASK, 32'h1);
		for (int m = 0; m < 4; m++) begin
			page(15'(m * 64 + 512), m == 0 ? 64 : m + 1, 2'(m));
			apb(0, `EPW_REG_IRQ, 32'h0);
			chk(rd, m == 0 ? 32'h3 : 32'h1);
			apb(0, `EPW_REG_STAT, 32'h0);
			chk(rd, 32'h0);
			apb(1, `EPW_REG_MASK, 32'h0);
			repeat (2) @(posedge pclk);
			chk(irq, 0);
			apb(1, `EPW_REG_IRQ, 32'h3);
			apb(1, `EPW_REG_MASK, 32'h1);
			repeat (2) @(posedge pclk);
			chk(irq, 0);
		end
		apb(0, 12'h020, 32'h0);
		chk(rd, 32'h0);
		chk(serr, 1);
		complete_run;
	end
endmodule // epw_host_tb_top
bind epw_host epw_host_props epw_host_props_inst (.pclk, .presetn, .psel, .penable, .pready,
	.pslverr, .mem_addr, .mem_data_oe, .chip_en_n, .out_en_n, .write_en_n);
`default_nettype wire
